// *** inc/icc_pkg.sv ***
package icc_pkg;
  // Register indices on the plain register port. Main control and the request registers sit in bank 0,
  // the enable registers in bank 1; the shadow copies sit in bank 31 (bank number in the upper address bits).
  localparam int          ADDR_W            = 12;
  localparam int          DATA_W            = 8;
  localparam logic [11:0] ADDR_MAIN_CONTROL = 12'h00B;
  localparam logic [11:0] ADDR_REQUEST_ONE  = 12'h011;
  localparam logic [11:0] ADDR_REQUEST_TWO  = 12'h012;
  localparam logic [11:0] ADDR_REQUEST_THREE = 12'h013;
  localparam logic [11:0] ADDR_ENABLE_ONE   = 12'h091;
  localparam logic [11:0] ADDR_ENABLE_TWO   = 12'h092;
  localparam logic [11:0] ADDR_ENABLE_THREE = 12'h093;
  localparam logic [4:0]  SHADOW_BANK       = 5'h1F;
  localparam logic [6:0]  SHADOW_BASE       = 7'h64;
  localparam int          SHADOW_COUNT      = 8;
  // Shadow slot order: working, status, bank select, pointer 0 low/high, pointer 1 low/high,
  // pc high latch.
  localparam logic [2:0]  SH_STATUS         = 3'h1;
  // Main control register bit positions.
  localparam int          BIT_GLOBAL_EN     = 7;
  localparam int          BIT_GROUP_EN      = 6;
  localparam int          BIT_TIMER0_EN     = 5;
  localparam int          BIT_EDGE_EN       = 4;
  localparam int          BIT_CHANGE_EN     = 3;
  localparam int          BIT_TIMER0_FLAG   = 2;
  localparam int          BIT_EDGE_FLAG     = 1;
  localparam int          BIT_CHANGE_FLAG   = 0;
  // Implemented-bit masks; the rest read as zero and ignore writes, except main control bit 0 (change summary) and request one bits 5:4 (serial flags).
  localparam logic [7:0]  MASK_MAIN_WR      = 8'hFE;
  localparam logic [7:0]  MASK_ONE          = 8'hFF;
  localparam logic [7:0]  MASK_TWO          = 8'hEF;
  localparam logic [7:0]  MASK_THREE        = 8'h37;
  // Receive and transmit flags follow their sources only.
  localparam logic [7:0]  MASK_REQ_ONE_WR   = 8'hCF;
  // Status bits kept out of the snapshot: time-out (4) and power-down (3).
  localparam logic [7:0]  STATUS_SAVE_MASK  = 8'hE7;
  localparam logic [7:0]  RESET_VALUE       = 8'h00;
  localparam logic [15:0] VECTOR_ADDR       = 16'h0004;
endpackage

// *** rtl/icc_top.sv ***
// Design decisions made here: the register offsets and the strobed register port.
`timescale 1ns/1ps
module icc_top
  import icc_pkg::*;
(
  input  wire logic              ref_clk,          // System clock, 100 MHz.
  input  wire logic              srst,             // Synchronous reset, active high.
  input  wire logic [ADDR_W-1:0] reg_addr,         // Register index.
  input  wire logic [7:0]        reg_wdata,        // Write data.
  input  wire logic              reg_wr,           // Write strobe.
  input  wire logic              reg_rd,           // Read strobe.
  output logic      [7:0]        reg_rdata,        // Read data, cycle after strobe.
  input  wire logic [7:0]        main_event,       // Core events: bit 2 timer0, bit 1 edge pin.
  input  wire logic              per_pin_change_flags, // Any per-pin change flag set.
  input  wire logic [7:0]        req_one_event,    // Peripheral group one event pulses.
  input  wire logic [7:0]        req_two_event,    // Peripheral group two event pulses.
  input  wire logic [7:0]        req_three_event,  // Peripheral group three event pulses.
  input  wire logic              serial_receive_flag,  // Receive buffer full level.
  input  wire logic              serial_transmit_flag, // Transmit buffer empty level.
  input  wire logic              core_ready,       // Core may accept an interrupt now.
  input  wire logic              return_from_interrupt, // Return instruction pulse.
  input  wire logic [15:0]       core_pc,          // Return program counter.
  input  wire logic [7:0]        core_ctx [SHADOW_COUNT], // Live core context.
  output logic                   irq_request,      // Gated request toward core.
  output logic                   irq_accept,       // Entry pulse: flush and vector.
  output logic                   stack_push,       // Push pulse.
  output logic      [15:0]       stack_push_pc,    // Value pushed.
  output logic                   stack_pop,        // Pop pulse on return.
  output logic      [15:0]       vector_pc,        // Vector address.
  output logic                   ctx_restore,      // Restore pulse: load context.
  output logic      [7:0]        ctx_restore_val [SHADOW_COUNT] // Values to restore.
);

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  // Change flags and serial levels come from logic on ref_clk; event
  // pulses and core handshakes are assumed synchronous too, so no resynchronisation is needed.

  // ---------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------
  logic [7:0]  main_reg, main_next;
  logic [7:0]  en_one_reg, en_one_next;
  logic [7:0]  en_two_reg, en_two_next;
  logic [7:0]  en_three_reg, en_three_next;
  logic [7:0]  req_one_reg, req_one_next;
  logic [7:0]  req_two_reg, req_two_next;
  logic [7:0]  req_three_reg, req_three_next;
  logic [7:0]  shadow_reg [SHADOW_COUNT];
  logic [7:0]  shadow_next [SHADOW_COUNT];
  logic [7:0]  rdata_reg, rdata_next;
  logic        req_reg, req_next;
  logic        accept_reg, accept_next;
  logic        pop_reg, pop_next;
  logic        restore_reg, restore_next;
  logic [15:0] push_pc_reg, push_pc_next;
  logic [15:0] vector_reg, vector_next;
  logic        pending;
  logic        wr_main, wr_r1, wr_r2, wr_r3;
  logic        is_shadow;
  logic [2:0]  sh_idx;
  logic [6:0]  sh_off;

  assign wr_main   = reg_wr && (reg_addr == ADDR_MAIN_CONTROL);
  assign wr_r1     = reg_wr && (reg_addr == ADDR_REQUEST_ONE);
  assign wr_r2     = reg_wr && (reg_addr == ADDR_REQUEST_TWO);
  assign wr_r3     = reg_wr && (reg_addr == ADDR_REQUEST_THREE);
  assign is_shadow = (reg_addr[11:7] == SHADOW_BANK) && (reg_addr[6:0] >= SHADOW_BASE)
                     && (reg_addr[6:0] < SHADOW_BASE + 7'(SHADOW_COUNT));
  assign sh_off    = reg_addr[6:0] - SHADOW_BASE;
  assign sh_idx    = sh_off[2:0];

  assign pending =
    (|(main_reg[5:3] & main_reg[2:0])) ||
    (main_reg[BIT_GROUP_EN] && (|(req_one_reg & en_one_reg) || |(req_two_reg & en_two_reg)
                                || |(req_three_reg & en_three_reg)));

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    main_next      = main_reg;
    en_one_next    = en_one_reg;
    en_two_next    = en_two_reg;
    en_three_next  = en_three_reg;
    req_one_next   = req_one_reg;
    req_two_next   = req_two_reg;
    req_three_next = req_three_reg;
    shadow_next    = shadow_reg;
    rdata_next     = 8'h00;
    accept_next    = 1'b0;
    pop_next       = 1'b0;
    restore_next   = 1'b0;
    push_pc_next   = push_pc_reg;
    // The vector is fixed, but it still leaves a flip-flop like every other output.
    vector_next    = VECTOR_ADDR;
    if (wr_main) begin
      main_next = (main_reg & ~MASK_MAIN_WR) | (reg_wdata & MASK_MAIN_WR);
    end
    if (reg_wr && reg_addr == ADDR_ENABLE_ONE) begin
      en_one_next = reg_wdata & MASK_ONE;
    end
    if (reg_wr && reg_addr == ADDR_ENABLE_TWO) begin
      en_two_next = reg_wdata & MASK_TWO;
    end
    if (reg_wr && reg_addr == ADDR_ENABLE_THREE) begin
      en_three_next = reg_wdata & MASK_THREE;
    end
    if (wr_r1) begin
      req_one_next = (req_one_reg & ~MASK_REQ_ONE_WR) | (reg_wdata & MASK_REQ_ONE_WR);
    end
    if (wr_r2) begin
      req_two_next = reg_wdata & MASK_TWO;
    end
    if (wr_r3) begin
      req_three_next = reg_wdata & MASK_THREE;
    end
    if (reg_wr && is_shadow) begin
      shadow_next[sh_idx] = reg_wdata;
    end
    main_next[BIT_TIMER0_FLAG] = main_next[BIT_TIMER0_FLAG] | main_event[BIT_TIMER0_FLAG];
    main_next[BIT_EDGE_FLAG]   = main_next[BIT_EDGE_FLAG] | main_event[BIT_EDGE_FLAG];
    main_next[BIT_CHANGE_FLAG] = per_pin_change_flags;
    req_one_next   = (req_one_next | (req_one_event & MASK_REQ_ONE_WR));
    req_one_next[5] = serial_receive_flag;
    req_one_next[4] = serial_transmit_flag;
    req_two_next   = req_two_next | (req_two_event & MASK_TWO);
    req_three_next = req_three_next | (req_three_event & MASK_THREE);
    if (main_reg[BIT_GLOBAL_EN] && pending && core_ready && !accept_reg) begin
      accept_next = 1'b1;
      main_next[BIT_GLOBAL_EN] = 1'b0;
      push_pc_next = core_pc;
      for (int i = 0; i < SHADOW_COUNT; i++) begin
        shadow_next[i] = (3'(i) == SH_STATUS) ? (core_ctx[i] & STATUS_SAVE_MASK) : core_ctx[i];
      end
    end else if (return_from_interrupt) begin
      pop_next = 1'b1;
      restore_next = 1'b1;
      main_next[BIT_GLOBAL_EN] = 1'b1;
    end
    if (reg_rd) begin
      case (reg_addr)
        ADDR_MAIN_CONTROL:  rdata_next = main_reg;
        ADDR_ENABLE_ONE:    rdata_next = en_one_reg;
        ADDR_ENABLE_TWO:    rdata_next = en_two_reg;
        ADDR_ENABLE_THREE:  rdata_next = en_three_reg;
        ADDR_REQUEST_ONE:   rdata_next = req_one_reg;
        ADDR_REQUEST_TWO:   rdata_next = req_two_reg;
        ADDR_REQUEST_THREE: rdata_next = req_three_reg;
        default:            rdata_next = is_shadow ? shadow_reg[sh_idx] : 8'h00;
      endcase
    end
    req_next = main_reg[BIT_GLOBAL_EN] && pending;
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      main_reg      <= RESET_VALUE;
      en_one_reg    <= RESET_VALUE;
      en_two_reg    <= RESET_VALUE;
      en_three_reg  <= RESET_VALUE;
      req_one_reg   <= RESET_VALUE;
      req_two_reg   <= RESET_VALUE;
      req_three_reg <= RESET_VALUE;
      for (int i = 0; i < SHADOW_COUNT; i++) begin
        shadow_reg[i] <= RESET_VALUE;
      end
      rdata_reg   <= RESET_VALUE;
      req_reg     <= 1'b0;
      accept_reg  <= 1'b0;
      pop_reg     <= 1'b0;
      restore_reg <= 1'b0;
      push_pc_reg <= 16'h0000;
      vector_reg  <= VECTOR_ADDR;
    end else begin
      main_reg      <= main_next;
      en_one_reg    <= en_one_next;
      en_two_reg    <= en_two_next;
      en_three_reg  <= en_three_next;
      req_one_reg   <= req_one_next;
      req_two_reg   <= req_two_next;
      req_three_reg <= req_three_next;
      shadow_reg    <= shadow_next;
      rdata_reg     <= rdata_next;
      req_reg       <= req_next;
      accept_reg    <= accept_next;
      pop_reg       <= pop_next;
      restore_reg   <= restore_next;
      push_pc_reg   <= push_pc_next;
      vector_reg    <= vector_next;
    end
  end

  assign reg_rdata       = rdata_reg;
  assign irq_request     = req_reg;
  assign irq_accept      = accept_reg;
  assign stack_push      = accept_reg;
  assign stack_push_pc   = push_pc_reg;
  assign stack_pop       = pop_reg;
  assign vector_pc       = vector_reg;
  assign ctx_restore     = restore_reg;
  assign ctx_restore_val = shadow_reg;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_entry_clears_global: assert property (@(posedge ref_clk) disable iff (srst)
    accept_reg |-> !main_reg[BIT_GLOBAL_EN]) else $error("global enable set after entry");
  a_no_entry_disabled: assert property (@(posedge ref_clk) disable iff (srst)
    !$past(main_reg[BIT_GLOBAL_EN]) |-> !accept_reg) else $error("entry while disabled");
  a_status_masked: assert property (@(posedge ref_clk) disable iff (srst)
    accept_reg |-> (shadow_reg[SH_STATUS] & ~STATUS_SAVE_MASK) == 8'h00)
    else $error("status snapshot kept excluded bits");
  a_snapshot_taken: assert property (@(posedge ref_clk) disable iff (srst)
    accept_reg |-> shadow_reg[0] == $past(core_ctx[0]) && push_pc_reg == $past(core_pc))
    else $error("context or pc not captured");
  a_return_reenables: assert property (@(posedge ref_clk) disable iff (srst)
    pop_reg |-> main_reg[BIT_GLOBAL_EN] && ctx_restore) else $error("return incomplete");
  a_event_sets_flag: assert property (@(posedge ref_clk) disable iff (srst)
    req_two_event[0] |=> req_two_reg[0]) else $error("event lost");
  a_group_gates: assert property (@(posedge ref_clk) disable iff (srst)
    (!main_reg[BIT_GROUP_EN] && !(|(main_reg[5:3] & main_reg[2:0]))) |=> !req_reg)
    else $error("peripheral request passed without group enable");
  a_unimpl_zero: assert property (@(posedge ref_clk) disable iff (srst)
    (en_three_reg & ~MASK_THREE) == 8'h00 && (req_two_reg & ~MASK_TWO) == 8'h00)
    else $error("unimplemented bit set");
  a_summary_tracks: assert property (@(posedge ref_clk) disable iff (srst)
    main_reg[BIT_CHANGE_FLAG] == $past(per_pin_change_flags)) else $error("summary wrong");

  // ---------------------------------------------------------------
  // Reset, flag and context checks
  // ---------------------------------------------------------------
  a_reset_clears: assert property (@(posedge ref_clk)
    srst |=> main_reg == RESET_VALUE && en_one_reg == RESET_VALUE
             && en_two_reg == RESET_VALUE && en_three_reg == RESET_VALUE)
    else $error("enable left set by reset");
  a_request_gated: assert property (@(posedge ref_clk) disable iff (srst)
    !main_reg[BIT_GLOBAL_EN] |=> !req_reg) else $error("request while globally disabled");
  a_accept_needs_ready: assert property (@(posedge ref_clk) disable iff (srst)
    accept_reg |-> $past(core_ready) && $past(pending)) else $error("entry without cause");
  a_timer_flag_sets: assert property (@(posedge ref_clk) disable iff (srst)
    main_event[BIT_TIMER0_FLAG] |=> main_reg[BIT_TIMER0_FLAG]) else $error("timer flag lost");
  a_edge_flag_sets: assert property (@(posedge ref_clk) disable iff (srst)
    main_event[BIT_EDGE_FLAG] |=> main_reg[BIT_EDGE_FLAG]) else $error("edge flag lost");
  a_serial_mirror: assert property (@(posedge ref_clk) disable iff (srst)
    req_one_reg[5:4] == $past({serial_receive_flag, serial_transmit_flag}))
    else $error("serial flags not mirrored");
  a_enable_masked: assert property (@(posedge ref_clk) disable iff (srst)
    (en_two_reg & ~MASK_TWO) == 8'h00 && (req_three_reg & ~MASK_THREE) == 8'h00)
    else $error("unimplemented bit set");
  // Shadows move only on entry or a software write, so a return never restores stale data.
  a_shadow_held: assert property (@(posedge ref_clk) disable iff (srst)
    !accept_reg && !$past(reg_wr && is_shadow) |-> shadow_reg[0] == $past(shadow_reg[0]))
    else $error("shadow changed without entry or write");
  a_pop_after_return: assert property (@(posedge ref_clk) disable iff (srst)
    return_from_interrupt && !(main_reg[BIT_GLOBAL_EN] && pending && core_ready && !accept_reg)
    |=> pop_reg && ctx_restore) else $error("return not carried out");
  a_push_pc_held: assert property (@(posedge ref_clk) disable iff (srst)
    !accept_reg |-> $stable(push_pc_reg)) else $error("pushed pc moved without entry");
endmodule

// *** testbench/icc_core_model.sv ***
`timescale 1ns/1ps
module icc_core_model
  import icc_pkg::*;
(
  input  wire logic        ref_clk,               // Clock.
  input  wire logic        srst,                  // Reset.
  input  wire logic        slow,                  // Delay readiness.
  input  wire logic        do_mod,                // Routine edits context.
  input  wire logic        do_ret,                // Routine ends.
  input  wire logic        irq_request,           // Gated request.
  output logic             core_ready,            // May take interrupt.
  output logic             return_from_interrupt, // Return pulse.
  output logic      [15:0] core_pc,               // Live pc.
  output logic      [7:0]  core_ctx [SHADOW_COUNT] // Live context.
);
  int wait_cnt = 0;

  always @(posedge ref_clk) begin
    if (srst) begin
      core_ready <= 1'b0;
      return_from_interrupt <= 1'b0;
      wait_cnt <= 0;
    end else begin
      return_from_interrupt <= do_ret;
      wait_cnt <= irq_request ? wait_cnt + 1 : 0;
      // A slow core leaves the request waiting three cycles.
      core_ready <= irq_request && (wait_cnt >= (slow ? 3 : 0));
    end
    if (srst || do_mod) begin
      core_pc <= 16'($urandom);
      foreach (core_ctx[i])
        core_ctx[i] <= 8'($urandom);
    end
  end
endmodule

// *** testbench/test_irq_control_context_save.sv ***
`timescale 1ns/1ps
module test_irq_control_context_save
  import icc_pkg::*;
;
  logic        ref_clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic [7:0]  reg_wdata = 8'h00, reg_rdata, main_event = 8'h00, req_one_event = 8'h00;
  logic [7:0]  req_two_event = 8'h00, req_three_event = 8'h00;
  logic        per_pin_change_flags = 1'b0, serial_receive_flag = 1'b0;
  logic        serial_transmit_flag = 1'b0, slow = 1'b0, do_mod = 1'b0, do_ret = 1'b0;
  logic        core_ready, return_from_interrupt, irq_request, irq_accept;
  logic        stack_push, stack_pop, ctx_restore;
  logic [15:0] core_pc, stack_push_pc, vector_pc;
  logic [7:0]  core_ctx [SHADOW_COUNT];
  logic [7:0]  ctx_restore_val [SHADOW_COUNT];
  logic [7:0]  mdl [int];
  logic [11:0] regs [7] = '{ADDR_MAIN_CONTROL, ADDR_REQUEST_ONE, ADDR_REQUEST_TWO,
    ADDR_REQUEST_THREE, ADDR_ENABLE_ONE, ADDR_ENABLE_TWO, ADDR_ENABLE_THREE};
  int          n_errors = 0, total_checks = 0, n_acc = 0, n_ret = 0;

  always #5 ref_clk = ~ref_clk;

  icc_top icc_top_inst (.ref_clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .main_event, .per_pin_change_flags, .req_one_event, .req_two_event,
    .req_three_event, .serial_receive_flag, .serial_transmit_flag, .core_ready,
    .return_from_interrupt, .core_pc, .core_ctx, .irq_request, .irq_accept, .stack_push,
    .stack_push_pc, .stack_pop, .vector_pc, .ctx_restore, .ctx_restore_val);
  icc_core_model icc_core_model_inst (.ref_clk, .srst, .slow, .do_mod, .do_ret,
    .irq_request, .core_ready, .return_from_interrupt, .core_pc, .core_ctx);

  function automatic logic [11:0] sh(int s);
    return {SHADOW_BANK, SHADOW_BASE + 7'(s)};
  endfunction
  function automatic logic [7:0] sm(int s);
    return (s == SH_STATUS) ? STATUS_SAVE_MASK : 8'hFF;
  endfunction
  function automatic logic [7:0] wm(logic [11:0] a);
    case (a)
      ADDR_MAIN_CONTROL: return MASK_MAIN_WR;
      ADDR_REQUEST_ONE: return MASK_REQ_ONE_WR;
      ADDR_ENABLE_ONE: return MASK_ONE;
      ADDR_REQUEST_TWO, ADDR_ENABLE_TWO: return MASK_TWO;
      ADDR_REQUEST_THREE, ADDR_ENABLE_THREE: return MASK_THREE;
      default: return (a >= sh(0) && a <= sh(7)) ? 8'hFF : 8'h00;
    endcase
  endfunction
  // Read-only live bits are not stored in the model; they are merged here.
  function automatic logic [7:0] ex(logic [11:0] a);
    ex = mdl[a];
    if (a == ADDR_MAIN_CONTROL) ex[0] = per_pin_change_flags;
    if (a == ADDR_REQUEST_ONE) ex[5:4] = {serial_receive_flag, serial_transmit_flag};
  endfunction

  task automatic end_of_test;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp, input logic [11:0] a);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %0t reg %h got %h exp %h", $time, a, got, exp);
    end
  endtask
  task automatic chk_out(input logic [15:0] got, input logic [15:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [7:0] ev);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    req_one_event <= ev;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    req_one_event <= 8'h00;
    mdl[a] = (d & wm(a)) | (mdl[a] & ~wm(a));
    mdl[ADDR_REQUEST_ONE] |= ev & MASK_REQ_ONE_WR;
  endtask
  task automatic rd_chk(input logic [11:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk_reg(reg_rdata, ex(a), a);
  endtask
  task automatic wait_for(ref int c, input int k);
    for (int i = 0; i < 50 && c < k; i++)
      @(posedge ref_clk);
    chk_out(16'(c), 16'(k), "event count");
  endtask

  always @(posedge ref_clk) begin
    if (irq_accept) begin
      n_acc++;
      mdl[ADDR_MAIN_CONTROL] &= 8'h7F;
      for (int s = 0; s < SHADOW_COUNT; s++)
        mdl[sh(s)] = core_ctx[s] & sm(s);
      chk_out(16'(stack_push), 16'h0001, "push");
      chk_out(stack_push_pc, core_pc, "pushed pc");
      chk_out(vector_pc, VECTOR_ADDR, "vector");
    end
    if (ctx_restore) begin
      n_ret++;
      mdl[ADDR_MAIN_CONTROL] |= 8'h80;
      chk_out(16'(stack_pop), 16'h0001, "pop");
      for (int s = 0; s < SHADOW_COUNT; s++)
        chk_out(16'(ctx_restore_val[s] & sm(s)), 16'(mdl[sh(s)]), "restore");
    end
  end

  initial begin
    repeat (5000) @(posedge ref_clk);
    n_errors++;
    $display("CHECK FAILED %0t watchdog expired", $time);
    end_of_test();
  end

  initial begin
    void'($urandom(64005));
    foreach (regs[i])
      mdl[regs[i]] = 8'h00;
    mdl[12'h7FF] = 8'h00;
    for (int s = 0; s < SHADOW_COUNT; s++)
      mdl[sh(s)] = 8'h00;
    repeat (10) @(posedge ref_clk);
    srst <= 1'b0;
    foreach (regs[i])
      rd_chk(regs[i]);
    for (int i = 1; i < 7; i++) begin
      wr(regs[i], 8'hFF, 8'h00);
      rd_chk(regs[i]);
      wr(regs[i], 8'h00, 8'h00);
    end
    serial_receive_flag <= 1'b1;
    serial_transmit_flag <= 1'($urandom);
    per_pin_change_flags <= 1'b1;
    wr(12'h7FF, 8'hFF, 8'h40);
    wr(ADDR_MAIN_CONTROL, 8'h00, 8'h00);
    rd_chk(12'h7FF);
    rd_chk(ADDR_REQUEST_ONE);
    rd_chk(ADDR_MAIN_CONTROL);
    wr(ADDR_REQUEST_ONE, 8'h00, 8'h40);
    rd_chk(ADDR_REQUEST_ONE);
    per_pin_change_flags <= 1'b0;
    serial_receive_flag <= 1'b0;
    serial_transmit_flag <= 1'b0;
    wr(ADDR_REQUEST_ONE, 8'h00, 8'h00);
    rd_chk(ADDR_MAIN_CONTROL);
    @(posedge ref_clk);
    main_event <= 8'hFF;
    req_two_event <= 8'hFF;
    req_three_event <= 8'hFF;
    @(posedge ref_clk);
    main_event <= 8'h00;
    req_two_event <= 8'h00;
    req_three_event <= 8'h00;
    mdl[ADDR_MAIN_CONTROL] |= 8'h06;
    mdl[ADDR_REQUEST_TWO] |= MASK_TWO;
    mdl[ADDR_REQUEST_THREE] |= MASK_THREE;
    for (int i = 0; i < 4; i++)
      rd_chk(regs[i]);
    for (int i = 0; i < 4; i++)
      wr(regs[i], 8'h00, 8'h00);
    // Enable bits 2 to 6 of the first group in turn, core prompt or slow at random each time.
    for (int b = 2; b < 7; b++) begin
      slow <= 1'($urandom);
      wr(ADDR_ENABLE_ONE, 8'(1 << b), 8'h00);
      serial_receive_flag <= (b == 5);
      serial_transmit_flag <= (b == 4);
      wr(ADDR_REQUEST_ONE, 8'h00, 8'(1 << b));
      wr(ADDR_MAIN_CONTROL, 8'h80, 8'h00);
      repeat (3) @(posedge ref_clk);
      chk_out(16'(irq_request), 16'h0000, "group off");
      wr(ADDR_MAIN_CONTROL, 8'hC0, 8'h00);
      wait_for(n_acc, b - 1);
      for (int s = 0; s < SHADOW_COUNT; s++)
        rd_chk(sh(s));
      do_mod <= 1'b1;
      @(posedge ref_clk);
      do_mod <= 1'b0;
      wr(sh(0), 8'($urandom), 8'h00);
      chk_out(16'(irq_request), 16'h0000, "held");
      serial_receive_flag <= 1'b0;
      serial_transmit_flag <= 1'b0;
      wr(ADDR_REQUEST_ONE, 8'h00, 8'h00);
      do_ret <= 1'b1;
      @(posedge ref_clk);
      do_ret <= 1'b0;
      wait_for(n_ret, b - 1);
      rd_chk(ADDR_MAIN_CONTROL);
      wr(ADDR_MAIN_CONTROL, 8'h00, 8'h00);
      wr(ADDR_ENABLE_ONE, 8'h00, 8'h00);
    end
    // Core sources need no group enable: the timer flag is set by software here.
    wr(ADDR_MAIN_CONTROL, 8'hA4, 8'h00);
    wait_for(n_acc, 6);
    wr(ADDR_MAIN_CONTROL, 8'h20, 8'h00);
    do_ret <= 1'b1;
    @(posedge ref_clk);
    do_ret <= 1'b0;
    wait_for(n_ret, 6);
    rd_chk(ADDR_MAIN_CONTROL);
    end_of_test();
  end
endmodule
